// *** verilog/gpi_pkg.sv ***
// constants for the port and pin interrupt block
package gpi_pkg;
	localparam int  NUM_PORTS  = 4;
	localparam int  NUM_CFG    = 3;
	localparam int  PORT_BITS  = 8;

	// data registers, index = port number
	localparam logic [3:0][7:0] PORT_ADDR = {8'hB0, 8'hA0, 8'h90, 8'h80};
	localparam logic [3:0][7:0] PORT_RST  = {8'h01, 8'h01, 8'hFF, 8'hFF};

	// configured ports 0, 1 and 3, index = cfg slot
	localparam logic [2:0][1:0] CFG_PORT   = {2'h3, 2'h1, 2'h0};
	localparam logic [2:0][7:0] MODEA_ADDR = {8'hC2, 8'hB3, 8'hB1};
	localparam logic [2:0][7:0] MODEB_ADDR = {8'hC3, 8'hB4, 8'hB2};
	localparam logic [2:0][7:0] SCHM_ADDR  = {8'hAC, 8'h83, 8'hB1};
	localparam logic [2:0][7:0] SLEW_ADDR  = {8'hAD, 8'h84, 8'h82};
	localparam logic [2:0][7:0] MODEA_RST  = {8'h01, 8'hFF, 8'hFF};
	localparam logic [7:0]      MODEB_RST  = 8'h00;
	localparam logic [7:0]      SCHM_RST   = 8'h00;
	localparam logic [7:0]      SLEW_RST   = 8'h00;

	localparam logic [7:0] ADDR_P2_SETUP  = 8'hB5;
	localparam logic [7:0] P2_SETUP_RST   = 8'h00;
	localparam logic [7:0] P2_SETUP_MASK  = 8'h8D;
	localparam int         P2S_PULLUP_BIT = 7;
	localparam int         P2S_TIMER1_OUT_ENABLE_BIT   = 3;
	localparam int         P2S_TIMER0_OUT_ENABLE_BIT   = 2;
	localparam int         P2S_SCHM_BIT   = 0;

	localparam logic [7:0] ADDR_IRQ_CTRL  = 8'hE9;
	localparam logic [7:0] ADDR_IRQ_FALL  = 8'hEA;
	localparam logic [7:0] ADDR_IRQ_RISE  = 8'hEB;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hEC;
	localparam logic [7:0] IRQ_REG_RST    = 8'h00;
	localparam int         IRQ_PS_LSB     = 0;
	localparam int         IRQ_PS_MSB     = 1;
	localparam logic [7:0] READ_ZERO      = 8'h00;

	// per-channel edge select from the control byte
	function automatic logic [7:0] gpi_edge_map(input logic [7:0] ctrl);
		gpi_edge_map = {ctrl[7], ctrl[7], ctrl[6], ctrl[6], ctrl[5], ctrl[4], ctrl[3], ctrl[2]};
	endfunction
endpackage

// *** verilog/gpi_irq_if.sv ***
// signals between the register side and the pin interrupt channels
`timescale 1ns/1ns
interface gpi_irq_if;
	logic [7:0] pins;
	logic [7:0] rise_en;
	logic [7:0] fall_en;
	logic [7:0] edge_mode;
	logic       wr_flags;
	logic [7:0] wdata;
	logic [7:0] flags;
	logic       irq_req;

	modport ctl  (output pins, rise_en, fall_en, edge_mode, wr_flags, wdata, input flags, irq_req);
	modport chan (input pins, rise_en, fall_en, edge_mode, wr_flags, wdata, output flags, irq_req);
endinterface

// *** verilog/gpi_pin_irq.sv ***
// eight pin interrupt channels with flags and combined request
`timescale 1ns/1ns
module gpi_pin_irq
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	gpi_irq_if.chan   bus
);
	logic [7:0] prev_ff;
	logic       primed_ff;
	logic [7:0] flag_ff;
	logic [7:0] nxt_flag;
	logic [7:0] chan_req;
	logic       irq_ff;

	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_chan
			wire rise_w = bus.pins[i] & ~prev_ff[i] & primed_ff;
			wire fall_w = ~bus.pins[i] & prev_ff[i] & primed_ff;
			wire set_w  = (rise_w & bus.rise_en[i]) | (fall_w & bus.fall_en[i]); // RL22
			wire base_w = bus.wr_flags ? bus.wdata[i] : flag_ff[i]; // RL18
			// set beats a same-cycle clear
			assign nxt_flag[i] = bus.edge_mode[i] ? (base_w | set_w) : ~bus.pins[i]; // RL21
			assign chan_req[i] = bus.edge_mode[i] ? flag_ff[i]
				: ((bus.pins[i] & bus.rise_en[i]) | (~bus.pins[i] & bus.fall_en[i])); // RL17
		end
	endgenerate

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prev_ff   <= 8'h00;
			primed_ff <= 1'b0;
			flag_ff   <= 8'h00;
			irq_ff    <= 1'b0;
		end
		else
		begin
			prev_ff   <= bus.pins; // RL22
			primed_ff <= 1'b1;
			flag_ff   <= nxt_flag; // RL18
			irq_ff    <= |chan_req; // RL19
		end
	end

	assign bus.flags   = flag_ff;
	assign bus.irq_req = irq_ff;
endmodule

// *** verilog/gpi_gpio_top.sv ***
// general purpose port block: latches, pin modes, input type, slew, pin interrupt
// What this block does
// [RL1] port data read gives pin levels; write loads the output latch
// [RL2] port data registers accept single-bit writes
// [RL3] reset: port 0/1 latches all ones, port 2/3 latches only bit 0
// [RL4] port 2 bit 0 input only while RESET_PIN_DISABLE_IN is low; else reads 0
// [RL5] port 3 bit 0 is I/O only on internal oscillator; else ignored, reads 0
// [RL6] two mode bits per pin: quasi, push-pull, input-only, open-drain
// [RL7] reset: port 0/1 pins input-only (mode a ones, mode b zeros); port 3 mode a 0x01, so bits 7:1 are quasi
// [RL8] per-pin schmitt bit: 0 TTL, 1 schmitt; reset 0
// [RL9] schmitt and slew registers reachable only on page 1
// [RL10] per-pin slew bit: 0 normal, 1 fast; reset normal
// [RL11] port 2 setup bit 7 pull-up only when pin is GPIO; reset pin keeps pull-up
// [RL12] port 2 setup bits 3,2 enable timer 1 and timer 0 pin outputs
// [RL13] port 2 setup bit 0 selects input type of port 2 bit 0
// [RL14] read-modify-write reads take the output latch, not the pins
// [RL15] bit operations rewrite the full latch, changing only one bit
// [RL16] eight interrupt channels mapped on one selectable port
// [RL17] per-channel rise/high and fall/low enables; control picks port and type
// [RL18] one hardware-set flag per channel; software clears edge flags
// [RL19] detected pin event can wake the CPU from idle or power-down
// [RL20] port select 00..11 picks port 0..3; type bit 0 level, 1 edge
// [RL21] level flags follow inverted pin, ignore writes; edge flags stick
// [RL22] edges found by comparing consecutive per-clock samples
`timescale 1ns/1ns
module gpi_gpio_top
#(
	parameter int PORT_WIDTH   = 8,
	parameter int IRQ_CHANNELS = 8
)
(
	input  wire logic       CLK_IN,
	input  wire logic       RST_IN,
	input  wire logic [7:0] SFR_ADDR_IN,
	input  wire logic       SFR_WR_IN,
	input  wire logic       SFR_RD_IN,
	input  wire logic [7:0] SFR_WDATA_IN,
	input  wire logic       SFR_PAGE1_IN,
	input  wire logic       SFR_RMW_IN,
	input  wire logic       SFR_BIT_WR_IN,
	input  wire logic [2:0] SFR_BIT_SEL_IN,
	input  wire logic       SFR_BIT_VAL_IN,
	input  wire logic       RESET_PIN_DISABLE_IN,
	input  wire logic       INT_OSC_SYSCLK_IN,
	input  wire logic [7:0] P0_PIN_IN,
	input  wire logic [7:0] P1_PIN_IN,
	input  wire logic [7:0] P2_PIN_IN,
	input  wire logic [7:0] P3_PIN_IN,
	output logic      [7:0] SFR_RDATA_OUT,
	output logic      [7:0] P0_PIN_OUT,
	output logic      [7:0] P0_PIN_OE_OUT,
	output logic      [7:0] P0_WEAK_PU_OUT,
	output logic      [7:0] P0_SCHMITT_OUT,
	output logic      [7:0] P0_FAST_SLEW_OUT,
	output logic      [7:0] P1_PIN_OUT,
	output logic      [7:0] P1_PIN_OE_OUT,
	output logic      [7:0] P1_WEAK_PU_OUT,
	output logic      [7:0] P1_SCHMITT_OUT,
	output logic      [7:0] P1_FAST_SLEW_OUT,
	output logic      [7:0] P3_PIN_OUT,
	output logic      [7:0] P3_PIN_OE_OUT,
	output logic      [7:0] P3_WEAK_PU_OUT,
	output logic      [7:0] P3_SCHMITT_OUT,
	output logic      [7:0] P3_FAST_SLEW_OUT,
	output logic            P2_PULLUP_OUT,
	output logic            P2_SCHMITT_OUT,
	output logic            TIMER0_PIN_EN_OUT,
	output logic            TIMER1_PIN_EN_OUT,
	output logic            PIN_IRQ_OUT,
	output logic            WAKE_OUT
);
	localparam int NP = gpi_pkg::NUM_PORTS;
	localparam int NC = gpi_pkg::NUM_CFG;

	// refuse sizes the fixed decode cannot serve
	generate
		if (PORT_WIDTH != gpi_pkg::PORT_BITS)
		begin : g_bad_width
			$error("port width must equal the register width");
		end

		if (IRQ_CHANNELS != PORT_WIDTH)
		begin : g_bad_chan
			$error("one interrupt channel per pin of the selected port");
		end

		if (NP != (1 << (gpi_pkg::IRQ_PS_MSB - gpi_pkg::IRQ_PS_LSB + 1)))
		begin : g_bad_sel
			$error("port select field must name every port");
		end

		if (NC != NP - 1)
		begin : g_bad_cfg
			$error("every port but port 2 needs a configuration slot");
		end

		if (gpi_pkg::CFG_PORT[NC-1] != 2'(NP - 1))
		begin : g_bad_last
			$error("last configuration slot must be the oscillator port");
		end

		if (gpi_pkg::IRQ_PS_LSB != 0)
		begin : g_bad_ps
			$error("edge type bits must sit directly above the port select field");
		end

		if (gpi_pkg::P2S_PULLUP_BIT >= PORT_WIDTH)
		begin : g_bad_p2s
			$error("setup bits must lie inside the register");
		end

		if (!gpi_pkg::P2_SETUP_MASK[gpi_pkg::P2S_TIMER1_OUT_ENABLE_BIT] || !gpi_pkg::P2_SETUP_MASK[gpi_pkg::P2S_TIMER0_OUT_ENABLE_BIT])
		begin : g_bad_mask
			$error("setup mask must keep both timer enables");
		end
	endgenerate

	// register state
	logic [NP-1:0][7:0] latch_ff;
	logic [NC-1:0][7:0] mode_a_ff;
	logic [NC-1:0][7:0] mode_b_ff;
	logic [NC-1:0][7:0] schm_ff;
	logic [NC-1:0][7:0] slew_ff;
	logic [7:0]         p2_setup_ff;
	logic [7:0]         irq_ctrl_ff;
	logic [7:0]         irq_rise_ff;
	logic [7:0]         irq_fall_ff;
	logic [7:0]         rdata_ff;

	// pin drive state, registered so outputs come from flops
	logic [NC-1:0][7:0] out_ff;
	logic [NC-1:0][7:0] oe_ff;
	logic [NC-1:0][7:0] pu_ff;
	logic               p2_pu_ff;
	logic               wake_ff;

	logic [NP-1:0][7:0] nxt_latch;
	logic [NP-1:0][7:0] pin_view;
	logic [NP-1:0][7:0] pin_in_w;
	logic [NP-1:0][7:0] port_rd;
	logic [NC-1:0][7:0] nxt_out;
	logic [NC-1:0][7:0] nxt_oe;
	logic [NC-1:0][7:0] nxt_pu;
	logic [NC-1:0][7:0] cfg_rd;
	logic [NC-1:0]      cfg_hit;
	logic [7:0]         nxt_rdata;

	gpi_irq_if irq_bus ();

	// shared decode
	wire any_wr       = SFR_WR_IN | SFR_BIT_WR_IN;
	wire p0_sch_page  = SFR_PAGE1_IN && (SFR_ADDR_IN == gpi_pkg::SCHM_ADDR[0]);
	wire p3_bit0_free = INT_OSC_SYSCLK_IN;
	wire p20_gpio     = ~RESET_PIN_DISABLE_IN;
	wire p2s_hit      = SFR_ADDR_IN == gpi_pkg::ADDR_P2_SETUP;
	wire ctrl_hit     = SFR_ADDR_IN == gpi_pkg::ADDR_IRQ_CTRL;
	wire fall_hit     = SFR_ADDR_IN == gpi_pkg::ADDR_IRQ_FALL;
	wire rise_hit     = SFR_ADDR_IN == gpi_pkg::ADDR_IRQ_RISE;
	wire flag_hit     = SFR_ADDR_IN == gpi_pkg::ADDR_IRQ_FLAGS;

	assign pin_in_w = {P3_PIN_IN, P2_PIN_IN, P1_PIN_IN, P0_PIN_IN};

	// what a plain read of each port shows
	assign pin_view[0] = P0_PIN_IN; // RL1
	assign pin_view[1] = P1_PIN_IN; // RL1
	assign pin_view[2] = {7'h00, P2_PIN_IN[0] & p20_gpio}; // RL4
	assign pin_view[3] = {P3_PIN_IN[7:1], P3_PIN_IN[0] & p3_bit0_free}; // RL5

	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_port
			wire       hit_w   = SFR_ADDR_IN == gpi_pkg::PORT_ADDR[p];
			// bit op: whole latch with one bit replaced
			wire [7:0] bit_w   = (latch_ff[p] & ~(8'h01 << SFR_BIT_SEL_IN))
				| ({7'h00, SFR_BIT_VAL_IN} << SFR_BIT_SEL_IN); // RL2 RL15
			wire [7:0] wval_w  = SFR_BIT_WR_IN ? bit_w : SFR_WDATA_IN;
			wire [7:0] keep_w  = (p == 3 && !p3_bit0_free) ? 8'h01 : 8'h00; // RL5
			wire [7:0] merge_w = (latch_ff[p] & keep_w) | (wval_w & ~keep_w);
			wire [7:0] rmw_w   = (p == 3 && !p3_bit0_free) ? (latch_ff[p] & 8'hFE) : latch_ff[p];
			assign nxt_latch[p] = (hit_w && any_wr) ? merge_w : latch_ff[p]; // RL1
			assign port_rd[p]   = SFR_RMW_IN ? rmw_w : pin_view[p]; // RL14
		end
	endgenerate

	genvar c;
	generate
		for (c = 0; c < NC; c++)
		begin : g_cfg
			wire [7:0] lat_w  = latch_ff[gpi_pkg::CFG_PORT[c]];
			// port 0 mode a shares its address with the page-1 schmitt register
			wire       ma_hit = (SFR_ADDR_IN == gpi_pkg::MODEA_ADDR[c]) && !(c == 0 && p0_sch_page);
			wire       mb_hit = SFR_ADDR_IN == gpi_pkg::MODEB_ADDR[c];
			wire       sc_hit = SFR_PAGE1_IN && (SFR_ADDR_IN == gpi_pkg::SCHM_ADDR[c]); // RL9
			wire       sl_hit = SFR_PAGE1_IN && (SFR_ADDR_IN == gpi_pkg::SLEW_ADDR[c]); // RL9
			wire [7:0] osc_w  = (c == 2 && !p3_bit0_free) ? 8'h01 : 8'h00; // RL5
			assign cfg_hit[c] = ma_hit | mb_hit | sc_hit | sl_hit;
			assign cfg_rd[c]  = ma_hit ? mode_a_ff[c] : mb_hit ? mode_b_ff[c]
				: sc_hit ? schm_ff[c] : sl_hit ? slew_ff[c] : gpi_pkg::READ_ZERO;

			// a=0 b=0 quasi, 0 1 push-pull, 1 0 input-only, 1 1 open-drain
			assign nxt_oe[c]  = ((mode_a_ff[c] & mode_b_ff[c] & ~lat_w)
				| (~mode_a_ff[c] & mode_b_ff[c])
				| (~mode_a_ff[c] & ~mode_b_ff[c] & ~lat_w)) & ~osc_w; // RL6
			assign nxt_pu[c]  = ~mode_a_ff[c] & ~mode_b_ff[c] & lat_w & ~osc_w; // RL6
			assign nxt_out[c] = lat_w;

			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
				begin
					mode_a_ff[c] <= gpi_pkg::MODEA_RST[c]; // RL7
					mode_b_ff[c] <= gpi_pkg::MODEB_RST; // RL7
					schm_ff[c]   <= gpi_pkg::SCHM_RST; // RL8
					slew_ff[c]   <= gpi_pkg::SLEW_RST; // RL10
				end
				else
				begin
					if (SFR_WR_IN && ma_hit)
						mode_a_ff[c] <= SFR_WDATA_IN; // RL6
					if (SFR_WR_IN && mb_hit)
						mode_b_ff[c] <= SFR_WDATA_IN; // RL6
					if (SFR_WR_IN && sc_hit)
						schm_ff[c] <= SFR_WDATA_IN; // RL8
					if (SFR_WR_IN && sl_hit)
						slew_ff[c] <= SFR_WDATA_IN; // RL10
				end
			end

			always_ff @(posedge CLK_IN or posedge RST_IN)
			begin
				if (RST_IN)
				begin
					out_ff[c] <= 8'h00;
					oe_ff[c]  <= 8'h00;
					pu_ff[c]  <= 8'h00;
				end
				else
				begin
					out_ff[c] <= nxt_out[c];
					oe_ff[c]  <= nxt_oe[c];
					pu_ff[c]  <= nxt_pu[c];
				end
			end
		end
	endgenerate

	// pin interrupt hookup
	assign irq_bus.pins      = pin_in_w[irq_ctrl_ff[gpi_pkg::IRQ_PS_MSB:gpi_pkg::IRQ_PS_LSB]]; // RL16 RL20
	assign irq_bus.rise_en   = irq_rise_ff; // RL17
	assign irq_bus.fall_en   = irq_fall_ff; // RL17
	assign irq_bus.edge_mode = gpi_pkg::gpi_edge_map(irq_ctrl_ff); // RL20
	assign irq_bus.wr_flags  = SFR_WR_IN && flag_hit; // RL18
	assign irq_bus.wdata     = SFR_WDATA_IN;

	gpi_pin_irq u_pin_irq
	(
		.clk_in (CLK_IN),
		.rst_in (RST_IN),
		.bus    (irq_bus)
	);

	// read data selection
	wire [7:0] port_sel = (SFR_ADDR_IN == gpi_pkg::PORT_ADDR[0]) ? port_rd[0]
		: (SFR_ADDR_IN == gpi_pkg::PORT_ADDR[1]) ? port_rd[1]
		: (SFR_ADDR_IN == gpi_pkg::PORT_ADDR[2]) ? port_rd[2]
		: (SFR_ADDR_IN == gpi_pkg::PORT_ADDR[3]) ? port_rd[3]
		: gpi_pkg::READ_ZERO;
	wire [7:0] cfg_sel  = cfg_hit[0] ? cfg_rd[0] : cfg_hit[1] ? cfg_rd[1]
		: cfg_hit[2] ? cfg_rd[2] : gpi_pkg::READ_ZERO;
	wire [7:0] irq_sel  = ctrl_hit ? irq_ctrl_ff : fall_hit ? irq_fall_ff
		: rise_hit ? irq_rise_ff : flag_hit ? irq_bus.flags : gpi_pkg::READ_ZERO;
	wire [7:0] p2s_sel  = p2s_hit ? (p2_setup_ff & gpi_pkg::P2_SETUP_MASK) : gpi_pkg::READ_ZERO;
	assign nxt_rdata = port_sel | cfg_sel | irq_sel | p2s_sel;

	// pull-up forced on while the pin serves as reset input
	wire nxt_p2_pu = ~p20_gpio | p2_setup_ff[gpi_pkg::P2S_PULLUP_BIT]; // RL11

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			latch_ff <= gpi_pkg::PORT_RST; // RL3
		else
			latch_ff <= nxt_latch; // RL1 RL15
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			p2_setup_ff <= gpi_pkg::P2_SETUP_RST;
			irq_ctrl_ff <= gpi_pkg::IRQ_REG_RST;
			irq_rise_ff <= gpi_pkg::IRQ_REG_RST;
			irq_fall_ff <= gpi_pkg::IRQ_REG_RST;
		end
		else
		begin
			if (SFR_WR_IN && p2s_hit)
				p2_setup_ff <= SFR_WDATA_IN & gpi_pkg::P2_SETUP_MASK; // RL12 RL13
			if (SFR_WR_IN && ctrl_hit)
				irq_ctrl_ff <= SFR_WDATA_IN; // RL17
			if (SFR_WR_IN && rise_hit)
				irq_rise_ff <= SFR_WDATA_IN; // RL17
			if (SFR_WR_IN && fall_hit)
				irq_fall_ff <= SFR_WDATA_IN; // RL17
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			rdata_ff <= 8'h00;
			p2_pu_ff <= 1'b0;
			wake_ff  <= 1'b0;
		end
		else
		begin
			if (SFR_RD_IN)
				rdata_ff <= nxt_rdata;
			p2_pu_ff <= nxt_p2_pu; // RL11
			wake_ff  <= irq_bus.irq_req; // RL19
		end
	end

	assign SFR_RDATA_OUT     = rdata_ff;
	assign P0_PIN_OUT        = out_ff[0];
	assign P0_PIN_OE_OUT     = oe_ff[0];
	assign P0_WEAK_PU_OUT    = pu_ff[0];
	assign P0_SCHMITT_OUT    = schm_ff[0]; // RL8
	assign P0_FAST_SLEW_OUT  = slew_ff[0]; // RL10
	assign P1_PIN_OUT        = out_ff[1];
	assign P1_PIN_OE_OUT     = oe_ff[1];
	assign P1_WEAK_PU_OUT    = pu_ff[1];
	assign P1_SCHMITT_OUT    = schm_ff[1];
	assign P1_FAST_SLEW_OUT  = slew_ff[1];
	assign P3_PIN_OUT        = out_ff[2];
	assign P3_PIN_OE_OUT     = oe_ff[2];
	assign P3_WEAK_PU_OUT    = pu_ff[2];
	assign P3_SCHMITT_OUT    = schm_ff[2];
	assign P3_FAST_SLEW_OUT  = slew_ff[2];
	assign P2_PULLUP_OUT     = p2_pu_ff;
	assign P2_SCHMITT_OUT    = p2_setup_ff[gpi_pkg::P2S_SCHM_BIT]; // RL13
	assign TIMER0_PIN_EN_OUT = p2_setup_ff[gpi_pkg::P2S_TIMER0_OUT_ENABLE_BIT]; // RL12
	assign TIMER1_PIN_EN_OUT = p2_setup_ff[gpi_pkg::P2S_TIMER1_OUT_ENABLE_BIT]; // RL12
	assign PIN_IRQ_OUT       = irq_bus.irq_req; // RL19
	assign WAKE_OUT          = wake_ff; // RL19
endmodule

// *** tb/gpi_pin_model.sv ***
// pin side model: keys and devices that drive or release the port pins
`timescale 1ns/1ns
module gpi_pin_model
(
	input  wire logic	clk_in,
	input  wire logic [7:0]	pin_in,
	input  wire logic [7:0]	oe_in,
	input  wire logic [7:0]	pu_in,
	input  wire logic [7:0]	ext_in,
	input  wire logic [7:0]	ext_en_in,
	output logic      [7:0]	lvl_out
);
	logic [7:0]	last_ff = 8'h00;
	logic [7:0]	float_lvl;

	// released line: pulled up, else toggles so a stale value never passes
	assign float_lvl = pu_in | ~last_ff;
	// strong device drive wins, then the external source
	assign lvl_out = (oe_in & pin_in) | (~oe_in & ext_en_in & ext_in) | (~oe_in & ~ext_en_in & float_lvl);

	always_ff @(posedge clk_in)
		last_ff <= lvl_out;
endmodule

// *** tb/gpi_gpio_asserts.sv ***
// concurrent checks on the port block's top-level ports
`timescale 1ns/1ns
module gpi_gpio_asserts
(
	input  wire logic	CLK_IN,
	input  wire logic	RST_IN,
	input  wire logic [7:0]	SFR_ADDR_IN,
	input  wire logic	SFR_WR_IN,
	input  wire logic	SFR_RD_IN,
	input  wire logic [7:0]	SFR_WDATA_IN,
	input  wire logic	SFR_PAGE1_IN,
	input  wire logic	SFR_RMW_IN,
	input  wire logic	RESET_PIN_DISABLE_IN,
	input  wire logic	INT_OSC_SYSCLK_IN,
	input  wire logic [7:0]	P0_PIN_IN,
	input  wire logic [7:0]	SFR_RDATA_OUT,
	input  wire logic [7:0]	P0_FAST_SLEW_OUT,
	input  wire logic	P2_PULLUP_OUT,
	input  wire logic	TIMER0_PIN_EN_OUT,
	input  wire logic	PIN_IRQ_OUT,
	input  wire logic	WAKE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence s_rd(logic [7:0] a);
		SFR_RD_IN && SFR_ADDR_IN == a && !SFR_RMW_IN;
	endsequence
	sequence s_slew_wr;
		SFR_WR_IN && SFR_PAGE1_IN && SFR_ADDR_IN == 8'h82;
	endsequence
	sequence s_setup_wr;
		SFR_WR_IN && SFR_ADDR_IN == 8'hB5;
	endsequence

	property p_pin_rd;
		s_rd(8'h80) |=> SFR_RDATA_OUT == $past(P0_PIN_IN);
	endproperty
	a_pin_rd: assert property (p_pin_rd) else $error("port pin read differs from pins");
	property p_rst_pin_rd;
		s_rd(8'hA0) ##0 RESET_PIN_DISABLE_IN |=> SFR_RDATA_OUT == 8'h00;
	endproperty
	a_rst_pin_rd: assert property (p_rst_pin_rd) else $error("reset pin bit not read as zero");
	property p_osc_pin_rd;
		SFR_RD_IN && SFR_ADDR_IN == 8'hB0 && !INT_OSC_SYSCLK_IN |=> !SFR_RDATA_OUT[0];
	endproperty
	a_osc_pin_rd: assert property (p_osc_pin_rd) else $error("oscillator pin bit not read as zero");
	property p_page_rd;
		SFR_RD_IN && !SFR_PAGE1_IN && SFR_ADDR_IN inside {8'h82, 8'h83, 8'h84, 8'hAC, 8'hAD}
			|=> SFR_RDATA_OUT == 8'h00;
	endproperty
	a_page_rd: assert property (p_page_rd) else $error("page one register seen on page zero");
	property p_pullup;
		RESET_PIN_DISABLE_IN ##1 RESET_PIN_DISABLE_IN |-> P2_PULLUP_OUT;
	endproperty
	a_pullup: assert property (p_pullup) else $error("reset pin pull-up off");
	property p_wake;
		$rose(PIN_IRQ_OUT) |=> WAKE_OUT;
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not follow pin request");
	property p_slew;
		s_slew_wr |=> P0_FAST_SLEW_OUT == $past(SFR_WDATA_IN);
	endproperty
	a_slew: assert property (p_slew) else $error("slew output not loaded from write");
	property p_timer;
		s_setup_wr |=> TIMER0_PIN_EN_OUT == $past(SFR_WDATA_IN[2]);
	endproperty
	a_timer: assert property (p_timer) else $error("timer pin enable not loaded");
endmodule

bind gpi_gpio_top gpi_gpio_asserts u_chk
(
	.CLK_IN, .RST_IN, .SFR_ADDR_IN, .SFR_WR_IN, .SFR_RD_IN, .SFR_WDATA_IN, .SFR_PAGE1_IN, .SFR_RMW_IN,
	.RESET_PIN_DISABLE_IN, .INT_OSC_SYSCLK_IN, .P0_PIN_IN, .SFR_RDATA_OUT, .P0_FAST_SLEW_OUT,
	.P2_PULLUP_OUT, .TIMER0_PIN_EN_OUT, .PIN_IRQ_OUT, .WAKE_OUT
);

// *** tb/tb_top.sv ***
// self-checking bench for the port and pin interrupt block
`timescale 1ns/1ns
module tb_top;
	logic		CLK_IN = 1'b0;
	logic		RST_IN = 1'b1;
	logic [7:0]	SFR_ADDR_IN = 8'h00, SFR_WDATA_IN = 8'h00;
	logic		SFR_WR_IN = 1'b0, SFR_RD_IN = 1'b0, SFR_RMW_IN = 1'b0, SFR_BIT_WR_IN = 1'b0;
	logic		SFR_PAGE1_IN = 1'b0, SFR_BIT_VAL_IN = 1'b0, RESET_PIN_DISABLE_IN = 1'b0, INT_OSC_SYSCLK_IN = 1'b1;
	logic [2:0]	SFR_BIT_SEL_IN = 3'h0;
	logic [7:0]	SFR_RDATA_OUT, P0_PIN_OUT, P0_PIN_OE_OUT, P0_WEAK_PU_OUT, P0_SCHMITT_OUT, P0_FAST_SLEW_OUT;
	logic [7:0]	P1_PIN_OUT, P1_PIN_OE_OUT, P1_WEAK_PU_OUT, P3_PIN_OUT, P3_PIN_OE_OUT, P3_WEAK_PU_OUT;
	logic [7:0]	P1_SCHMITT_OUT, P1_FAST_SLEW_OUT, P3_SCHMITT_OUT, P3_FAST_SLEW_OUT;
	logic		P2_PULLUP_OUT, P2_SCHMITT_OUT, TIMER0_PIN_EN_OUT, TIMER1_PIN_EN_OUT, PIN_IRQ_OUT, WAKE_OUT;
	wire [7:0]	P0_PIN_IN, P1_PIN_IN, P2_PIN_IN, P3_PIN_IN;
	logic [7:0]	ext [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0]	ext_en = 8'hFF, d, m;
	logic [7:0]	exp_q [$];
	int		err_count = 0, cmp_count = 0;
	logic [16:0]	rst_tab [21] = '{17'h080FF, 17'h090FF, 17'h0B001, 17'h0B1FF, 17'h0B3FF, 17'h0C201, 17'h0B200,
				17'h0B400, 17'h0C300, 17'h0B500, 17'h0E900, 17'h0EA00, 17'h0EB00, 17'h0EC00, 17'h08100,
				17'h1B100, 17'h18300, 17'h1AC00, 17'h18200, 17'h18400, 17'h1AD00};
	wire [7:0]	p2s_vec = {P2_PULLUP_OUT, P2_SCHMITT_OUT, TIMER1_PIN_EN_OUT, TIMER0_PIN_EN_OUT, 4'h0};

	assign P2_PIN_IN = ext[2];
	always #25 CLK_IN = ~CLK_IN;

	gpi_gpio_top uut
	(
		.CLK_IN, .RST_IN, .SFR_ADDR_IN, .SFR_WR_IN, .SFR_RD_IN, .SFR_WDATA_IN, .SFR_PAGE1_IN, .SFR_RMW_IN,
		.SFR_BIT_WR_IN, .SFR_BIT_SEL_IN, .SFR_BIT_VAL_IN, .RESET_PIN_DISABLE_IN, .INT_OSC_SYSCLK_IN,
		.P0_PIN_IN, .P1_PIN_IN, .P2_PIN_IN, .P3_PIN_IN, .SFR_RDATA_OUT, .P0_PIN_OUT, .P0_PIN_OE_OUT,
		.P0_WEAK_PU_OUT, .P0_SCHMITT_OUT, .P0_FAST_SLEW_OUT, .P1_PIN_OUT, .P1_PIN_OE_OUT, .P1_WEAK_PU_OUT,
		.P1_SCHMITT_OUT, .P1_FAST_SLEW_OUT, .P3_PIN_OUT, .P3_PIN_OE_OUT, .P3_WEAK_PU_OUT,
		.P3_SCHMITT_OUT, .P3_FAST_SLEW_OUT, .P2_PULLUP_OUT, .P2_SCHMITT_OUT, .TIMER0_PIN_EN_OUT,
		.TIMER1_PIN_EN_OUT, .PIN_IRQ_OUT, .WAKE_OUT
	);
	gpi_pin_model m0 (.clk_in(CLK_IN), .pin_in(P0_PIN_OUT), .oe_in(P0_PIN_OE_OUT), .pu_in(P0_WEAK_PU_OUT),
		.ext_in(ext[0]), .ext_en_in(ext_en), .lvl_out(P0_PIN_IN));
	gpi_pin_model m1 (.clk_in(CLK_IN), .pin_in(P1_PIN_OUT), .oe_in(P1_PIN_OE_OUT), .pu_in(P1_WEAK_PU_OUT),
		.ext_in(ext[1]), .ext_en_in(8'hFF), .lvl_out(P1_PIN_IN));
	gpi_pin_model m3 (.clk_in(CLK_IN), .pin_in(P3_PIN_OUT), .oe_in(P3_PIN_OE_OUT), .pu_in(P3_WEAK_PU_OUT),
		.ext_in(ext[3]), .ext_en_in(8'hFF), .lvl_out(P3_PIN_IN));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one bus cycle; strobes held until the next call or idle
	task automatic op(input logic w, r, rmw, b, input logic [7:0] a, dat, e);
		{SFR_WR_IN, SFR_RD_IN, SFR_RMW_IN, SFR_BIT_WR_IN} = {w, r, rmw, b};
		SFR_ADDR_IN = a;
		SFR_WDATA_IN = dat;
		{SFR_BIT_VAL_IN, SFR_BIT_SEL_IN} = dat[3:0];
		if (r)
			exp_q.push_back(e);
		@(posedge CLK_IN);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, dat);
		op(1'b1, 1'b0, 1'b0, 1'b0, a, dat, 8'h00);
	endtask
	task automatic rd(input logic [7:0] a, e);
		op(1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00, e);
	endtask
	task automatic rm(input logic [7:0] a, e);
		op(1'b0, 1'b1, 1'b1, 1'b0, a, 8'h00, e);
	endtask
	task automatic bw(input logic [7:0] a, input logic [3:0] vs);
		op(1'b0, 1'b0, 1'b0, 1'b1, a, {4'h0, vs}, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) op(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
	endtask

	// read data lands one edge after the strobe
	always @(posedge CLK_IN)
		if (SFR_RD_IN === 1'b1)
		begin
			#2;
			chk(SFR_RDATA_OUT, exp_q.pop_front());
		end

	initial
	begin
		repeat (20000) @(posedge CLK_IN);
		err_count++;
		complete_run();
	end

	initial
	begin
		void'($urandom(24));
		repeat (2) @(posedge CLK_IN);
		#1;
		RST_IN = 1'b0;
		chk(P0_PIN_OE_OUT, 8'h00);
		foreach (rst_tab[i])
		begin
			SFR_PAGE1_IN = rst_tab[i][16];
			rm(rst_tab[i][15:8], rst_tab[i][7:0]);
		end
		SFR_PAGE1_IN = 1'b0;
		chk(P1_PIN_OE_OUT, 8'h00);
		chk(P1_WEAK_PU_OUT, 8'h00);
		chk(P1_PIN_OUT, 8'hFF);
		chk(P3_PIN_OE_OUT, 8'hFE);
		chk(P3_WEAK_PU_OUT, 8'h00);
		chk(P3_PIN_OUT, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			foreach (ext[i]) ext[i] = 8'($urandom);
			{INT_OSC_SYSCLK_IN, RESET_PIN_DISABLE_IN} = 2'(k);
			rd(8'h80, ext[0]);
			rd(8'h90, ext[1]);
			rd(8'hA0, {7'h00, ext[2][0] & ~RESET_PIN_DISABLE_IN});
			rd(8'hB0, {7'h00, ext[3][0] & INT_OSC_SYSCLK_IN});
		end
		{INT_OSC_SYSCLK_IN, RESET_PIN_DISABLE_IN} = 2'h2;
		wr(8'h80, 8'hA5);
		wr(8'hB1, 8'hF0);
		wr(8'hB2, 8'hCC);
		idle(2);
		ext_en = 8'hFE;
		rm(8'h80, 8'hA5);
		chk(P0_PIN_OE_OUT, 8'h4E);
		chk(P0_WEAK_PU_OUT, 8'h01);
		rd(8'h80, 8'h05 | (ext[0] & 8'hB0));
		bw(8'h80, 4'hC);
		bw(8'h80, 4'h0);
		rm(8'h80, 8'hB4);
		chk(P0_PIN_OUT, 8'hB4);
		INT_OSC_SYSCLK_IN = 1'b0;
		bw(8'hB0, 4'h0);
		INT_OSC_SYSCLK_IN = 1'b1;
		rm(8'hB0, 8'h01);
		d = 8'($urandom);
		SFR_PAGE1_IN = 1'b1;
		wr(8'h82, d);
		wr(8'hB1, ~d);
		SFR_PAGE1_IN = 1'b0;
		wr(8'h82, 8'h00);
		rd(8'h82, 8'h00);
		rd(8'hB1, 8'hF0);
		chk(P0_FAST_SLEW_OUT, d);
		chk(P0_SCHMITT_OUT, ~d);
		SFR_PAGE1_IN = 1'b1;
		for (int i = 1; i < 3; i++)
		begin
			wr(gpi_pkg::SCHM_ADDR[i], d);
			wr(gpi_pkg::SLEW_ADDR[i], ~d);
			rd(gpi_pkg::SCHM_ADDR[i], d);
			rd(gpi_pkg::SLEW_ADDR[i], ~d);
		end
		SFR_PAGE1_IN = 1'b0;
		chk(P1_SCHMITT_OUT, d);
		chk(P1_FAST_SLEW_OUT, ~d);
		chk(P3_SCHMITT_OUT, d);
		chk(P3_FAST_SLEW_OUT, ~d);
		wr(8'hB5, 8'hFF);
		rd(8'hB5, 8'h8D);
		chk(p2s_vec, 8'hF0);
		wr(8'hB5, 8'h00);
		idle(2);
		chk(p2s_vec, 8'h00);
		RESET_PIN_DISABLE_IN = 1'b1;
		idle(2);
		chk(p2s_vec, 8'h80);
		RESET_PIN_DISABLE_IN = 1'b0;
		wr(8'hC2, 8'hFF);
		for (int ps = 0; ps < 4; ps++)
		begin
			m = 8'h10 << ps;
			ext[ps] = ext[ps] | m;
			wr(8'hE9, {6'h3F, 2'(ps)});
			wr(8'hEA, m);
			wr(8'hEB, 8'h00);
			wr(8'hEC, 8'h00);
			ext[ps] = ext[ps] & ~m;
			idle(4);
			chk({6'h00, PIN_IRQ_OUT, WAKE_OUT}, 8'h03);
			rd(8'hEC, m);
			wr(8'hEA, 8'h00);
			wr(8'hEB, m);
			wr(8'hEC, 8'h00);
			ext[ps] = ext[ps] | m;
			idle(4);
			rd(8'hEC, m);
		end
		wr(8'hE9, 8'h01);
		ext[1] = 8'hF0;
		wr(8'hEC, 8'hFF);
		idle(2);
		rd(8'hEC, 8'h0F);
		wr(8'hEB, 8'h00);
		idle(2);
		chk({6'h00, PIN_IRQ_OUT, WAKE_OUT}, 8'h00);
		wr(8'hEA, 8'h01);
		idle(2);
		chk({6'h00, PIN_IRQ_OUT, WAKE_OUT}, 8'h03);
		idle(2);
		complete_run();
	end
endmodule
